// ### design/tnc_core.sv
// token-net core host control: registers, command queues, interrupt release
// assumes: AXI4-Lite master on aclk, network engine events arrive as one-cycle pulses
// Behaviour
// - chaining holds two transmit, two receive commands
// - no chaining holds one of each
// - chaining keeps status per outstanding command
// - transmit enable lets transmitter drive network
// - unchained: only masking releases receive interrupt
// - chained: clear command releases receive interrupt
// - core idle until non-zero node id
// - diagnostic read clears duplicate-id flag
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "tnc_consts.svh"
module tnc_core
	import tnc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic tx_done, // engine finished oldest transmit (pulse)
	input wire logic tx_ok, // its packet was acknowledged
	input wire logic rx_done, // engine filled oldest receive buffer (pulse)
	input wire logic recon_seen, // reconfiguration seen (pulse)
	input wire logic token_seen, // token by another node (pulse)
	input wire logic rx_activity, // line activity (pulse)
	input wire logic dup_detect, // node id answered by another node (pulse)
	input wire logic my_recon, // own token timer expired (pulse)
	output logic core_run, // microsequencer allowed to run
	output logic tx_drive_en, // transmitter may drive network
	output logic tx_start, // start transmit from queue head (pulse)
	output logic rx_arm, // a receive buffer is armed
	output logic irq
);
	// bus channel state
	logic aw_full_q, aw_full_d; // write address held
	logic [7:0] aw_addr_q, aw_addr_d;
	logic w_full_q, w_full_d; // write data held
	logic [31:0] w_data_q, w_data_d;
	logic [3:0] w_strb_q, w_strb_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	// block state
	tnc_state_t state_q, state_d;
	logic [7:0] node_id_q, node_id_d;
	logic [7:0] config_q, config_d;
	logic [7:0] setup_q, setup_d;
	logic [3:0] imask_q, imask_d;
	logic txdone_q, txdone_d; // sticky transmit-done status
	logic recon_q, recon_d; // sticky recon status
	logic rxinh_q, rxinh_d; // receive interrupt latch
	tnc_cnt_t tx_cnt_q, tx_cnt_d; // pending transmits
	tnc_cnt_t rx_cnt_q, rx_cnt_d; // pending receives
	logic [1:0] tx_stat_q, tx_stat_d; // per-command transmit result
	logic [1:0] rx_stat_q, rx_stat_d; // per-command receive done
	logic [3:0] diag_q, diag_d;
	logic tx_go_q, tx_go_d;
	// decode helpers
	logic wr_fire, rd_fire, chain;
	tnc_cnt_t cap;
	logic [3:0] status_vec;
	logic [3:0] cmd;
	assign chain = setup_q[`TNC_SET_CHAIN];
	// capacity depends on the mode so both queues shrink together
	assign cap = chain ? 2'h2 : 2'h1;
	assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
	assign rd_fire = s_axi_arvalid && !rvalid_q;
	assign cmd = w_data_q[3:0];
	assign status_vec = {recon_q, rxinh_q, 1'b0, txdone_q};
	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready = !w_full_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign core_run = (state_q != TNC_SLEEP);
	assign tx_drive_en = (state_q == TNC_MEMBER);
	assign tx_start = tx_go_q;
	assign rx_arm = (rx_cnt_q != 2'h0);
	// receive interrupt stays up until masked or, when chained, cleared by command
	assign irq = |(status_vec & imask_q);

	// bus channel next state: address and data accepted in either order
	always_comb begin
		aw_full_d = aw_full_q;
		aw_addr_d = aw_addr_q;
		w_full_d = w_full_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (s_axi_awvalid && !aw_full_q) begin
			aw_full_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_full_q) begin
			w_full_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = (aw_addr_q[7:2] > `TNC_OFF_DEPTH >> 2) ? `TNC_RESP_SLVERR : `TNC_RESP_OKAY;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (rd_fire) begin
			rvalid_d = 1'b1;
			rresp_d = `TNC_RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'b00})
				`TNC_OFF_STATUS: rdata_d = {28'h0000000, status_vec};
				`TNC_OFF_IMASK: rdata_d = {28'h0000000, imask_q};
				`TNC_OFF_CMD: rdata_d = 32'h00000000;
				`TNC_OFF_CONFIG: rdata_d = {24'h000000, config_q};
				`TNC_OFF_NODEID: rdata_d = {24'h000000, node_id_q};
				`TNC_OFF_DIAG: rdata_d = {28'h0000000, diag_q};
				`TNC_OFF_SETUP: rdata_d = {24'h000000, setup_q};
				// per-command status shows in both modes; unchained fills only the low bit
				`TNC_OFF_DEPTH: rdata_d = {20'h00000, rx_stat_q, tx_stat_q, 4'h0,
					rx_cnt_q, tx_cnt_q};
				default: begin
					rdata_d = 32'h00000000;
					rresp_d = `TNC_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	// bus channel registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_full_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= 2'h0;
		end else begin
			aw_full_q <= aw_full_d;
			aw_addr_q <= aw_addr_d;
			w_full_q <= w_full_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// block next state: registers, queues, sticky flags
	always_comb begin
		logic wr_ok;
		logic diag_rd;
		wr_ok = wr_fire && w_strb_q[0];
		diag_rd = rd_fire && ({s_axi_araddr[7:2], 2'b00} == `TNC_OFF_DIAG);
		state_d = state_q;
		node_id_d = node_id_q;
		config_d = config_q;
		setup_d = setup_q;
		imask_d = imask_q;
		txdone_d = txdone_q;
		recon_d = recon_q;
		rxinh_d = rxinh_q;
		tx_cnt_d = tx_cnt_q;
		rx_cnt_d = rx_cnt_q;
		tx_stat_d = tx_stat_q;
		rx_stat_d = rx_stat_q;
		diag_d = diag_q;
		tx_go_d = 1'b0;
		// a read empties diagnostics; events in the same cycle survive
		if (diag_rd) begin
			diag_d = 4'h0;
		end
		if (state_q != TNC_SLEEP) begin
			if (token_seen) diag_d[`TNC_DG_TOKEN] = 1'b1;
			if (rx_activity) diag_d[`TNC_DG_RECEIVE_ACTIVITY_FLAG] = 1'b1;
			if (dup_detect) diag_d[`TNC_DG_DUPLICATE_IDENTIFIER_FLAG] = 1'b1;
			if (my_recon) diag_d[`TNC_DG_MYRECON] = 1'b1;
		end
		// software writes; write-one-to-clear on the status transmit-done and recon bits
		if (wr_ok) begin
			case (aw_addr_q)
				`TNC_OFF_STATUS: begin
					if (w_data_q[`TNC_ST_TXDONE]) txdone_d = 1'b0;
					if (w_data_q[`TNC_ST_RECON]) recon_d = 1'b0;
				end
				`TNC_OFF_IMASK: imask_d = w_data_q[3:0];
				`TNC_OFF_CONFIG: config_d = w_data_q[7:0];
				`TNC_OFF_SETUP: setup_d = w_data_q[7:0];
				`TNC_OFF_NODEID: node_id_d = w_data_q[7:0];
				`TNC_OFF_CMD: begin
					case (cmd)
						// commands beyond capacity are dropped
						`TNC_CMD_TX: if (tx_cnt_q < cap) tx_cnt_d = tx_cnt_q + 2'h1;
						`TNC_CMD_RX: if (rx_cnt_q < cap) rx_cnt_d = rx_cnt_q + 2'h1;
						`TNC_CMD_DIS_TX: tx_cnt_d = 2'h0;
						`TNC_CMD_DIS_RX: rx_cnt_d = 2'h0;
						`TNC_CMD_CLR_TX: if (chain) tx_stat_d = {1'b0, tx_stat_q[1]};
						// only chaining lets a command drop the receive interrupt
						`TNC_CMD_CLR_RX: if (chain) begin
							rxinh_d = 1'b0;
							rx_stat_d = {1'b0, rx_stat_q[1]};
						end
						default: ;
					endcase
				end
				default: ;
			endcase
		end
		// wake on a non-zero id, sleep again on zero
		case (state_q)
			TNC_SLEEP: if (node_id_q != 8'h00) state_d = TNC_AWAKE;
			TNC_AWAKE: begin
				if (node_id_q == 8'h00) state_d = TNC_SLEEP;
				else if (config_q[`TNC_CFG_TRANSMIT_ENABLE_BIT]) state_d = TNC_MEMBER;
			end
			TNC_MEMBER: begin
				if (node_id_q == 8'h00) state_d = TNC_SLEEP;
				else if (!config_q[`TNC_CFG_TRANSMIT_ENABLE_BIT]) state_d = TNC_AWAKE;
			end
			default: state_d = TNC_SLEEP;
		endcase
		// engine completions; sets beat clears in the same cycle
		if (state_q == TNC_MEMBER && tx_cnt_q != 2'h0 && !tx_go_q) tx_go_d = tx_done;
		if (tx_done && tx_cnt_q != 2'h0) begin
			// a disable in the same cycle has already emptied the queue; do not wrap
			if (tx_cnt_d != 2'h0) tx_cnt_d = tx_cnt_d - 2'h1;
			txdone_d = 1'b1;
			tx_stat_d = chain ? {tx_ok, tx_stat_q[0]} : {1'b0, tx_ok};
		end
		if (rx_done && rx_cnt_q != 2'h0 && state_q != TNC_SLEEP) begin
			if (rx_cnt_d != 2'h0) rx_cnt_d = rx_cnt_d - 2'h1;
			rxinh_d = 1'b1;
			rx_stat_d = chain ? {1'b1, rx_stat_q[0]} : 2'h1;
		end
		if (recon_seen && state_q != TNC_SLEEP) recon_d = 1'b1;
	end

	// block registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= TNC_SLEEP;
			node_id_q <= 8'h00;
			config_q <= 8'h00;
			setup_q <= 8'h00;
			imask_q <= 4'h0;
			txdone_q <= 1'b0;
			recon_q <= 1'b0;
			rxinh_q <= 1'b0;
			tx_cnt_q <= 2'h0;
			rx_cnt_q <= 2'h0;
			tx_stat_q <= 2'h0;
			rx_stat_q <= 2'h0;
			diag_q <= 4'h0;
			tx_go_q <= 1'b0;
		end else begin
			state_q <= state_d;
			node_id_q <= node_id_d;
			config_q <= config_d;
			setup_q <= setup_d;
			imask_q <= imask_d;
			txdone_q <= txdone_d;
			recon_q <= recon_d;
			rxinh_q <= rxinh_d;
			tx_cnt_q <= tx_cnt_d;
			rx_cnt_q <= rx_cnt_d;
			tx_stat_q <= tx_stat_d;
			rx_stat_q <= rx_stat_d;
			diag_q <= diag_d;
			tx_go_q <= tx_go_d;
		end
	end
endmodule : tnc_core

// ### design/tnc_consts.svh
// register offsets, field positions, command codes and responses for the token-net host control
// assumes: included by the core module and the test bench; AXI4-Lite byte addresses
`ifndef TNC_CONSTS_SVH
`define TNC_CONSTS_SVH
`define TNC_ADDR_W 8
`define TNC_OFF_STATUS 8'h00
`define TNC_OFF_IMASK 8'h04
`define TNC_OFF_CMD 8'h08
`define TNC_OFF_CONFIG 8'h0C
`define TNC_OFF_NODEID 8'h10
`define TNC_OFF_DIAG 8'h14
`define TNC_OFF_SETUP 8'h18
`define TNC_OFF_DEPTH 8'h1C
// status / mask bits
`define TNC_ST_TXDONE 0
`define TNC_ST_RXINH 2
`define TNC_ST_RECON 3
// config bits
`define TNC_CFG_TRANSMIT_ENABLE_BIT 5
// setup bits
`define TNC_SET_CHAIN 0
// command codes (low nibble of the command write)
`define TNC_CMD_TX 4'h3
`define TNC_CMD_RX 4'h4
`define TNC_CMD_CLR_TX 4'h5
`define TNC_CMD_CLR_RX 4'h6
`define TNC_CMD_DIS_TX 4'h1
`define TNC_CMD_DIS_RX 4'h2
// diagnostic bits
`define TNC_DG_TOKEN 0
`define TNC_DG_RECEIVE_ACTIVITY_FLAG 1
`define TNC_DG_DUPLICATE_IDENTIFIER_FLAG 2
`define TNC_DG_MYRECON 3
`define TNC_RESP_OKAY 2'h0
`define TNC_RESP_SLVERR 2'h2
`endif

// ### design/tnc_pkg.sv
// types for the token-net host control core
// assumes: the constants header sits beside it
package tnc_pkg;
	typedef enum logic [1:0] {
		TNC_SLEEP,
		TNC_AWAKE,
		TNC_MEMBER
	} tnc_state_t;
	typedef logic [1:0] tnc_cnt_t; // pending commands per direction
endpackage : tnc_pkg

// ### bench/tnc_props.sv
// checker for the token-net host control ports
// assumes: bound to tnc_core, one clock domain on aclk
`timescale 1ns/1ns
module tnc_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_done,
	input wire logic core_run,
	input wire logic tx_drive_en,
	input wire logic rx_arm,
	input wire logic irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// the core only falls asleep again after a node id write of zero
	a_run_sticky: assert property ($fell(core_run) |-> $past(s_axi_bvalid))
		else $error("core run dropped");
	a_drive_awake: assert property (tx_drive_en |-> core_run)
		else $error("transmitter drives while asleep");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write not answered");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read data dropped");
	a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	// only a register write may lower the interrupt
	a_irq_release: assert property ($fell(irq) |-> s_axi_bvalid)
		else $error("interrupt released without write");
	a_arm_release: assert property ($fell(rx_arm) |-> $past(rx_done) || s_axi_bvalid)
		else $error("receive queue emptied without cause");
	c_irq: cover property ($rose(irq));
	c_member: cover property ($rose(tx_drive_en));
	c_arm: cover property ($fell(rx_arm));
endmodule : tnc_props
bind tnc_core tnc_props u_tnc_props (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.rx_done(rx_done), .core_run(core_run), .tx_drive_en(tx_drive_en), .rx_arm(rx_arm),
	.irq(irq));

// ### bench/tnc_engine.sv
// network engine model: one-cycle event pulses on request
// assumes: fire is called just after a rising aclk edge
`timescale 1ns/1ns
module tnc_engine (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic rx_arm,
	output logic [7:0] ev
);
	logic [7:0] ev_q = 8'h00; // pending pulses
	// no reception lands in an unarmed buffer, like the real engine
	assign ev = aresetn ? (ev_q & {5'h1F, rx_arm, 2'h3}) : 8'h00;
	task automatic fire(input logic [7:0] v);
		ev_q <= v;
		@(posedge aclk);
		ev_q <= 8'h00;
		@(posedge aclk);
	endtask : fire
endmodule : tnc_engine

// ### bench/token_net_core_host_control_test.sv
// self-checking bench for the token-net host control
// assumes: tnc_core, tnc_engine and the bound checker are compiled first
`timescale 1ns/1ns
`include "tnc_consts.svh"
module token_net_core_host_control_test;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF; // full words only
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
	logic [31:0] s_axi_rdata, rd_data;
	logic core_run, tx_drive_en, rx_arm, irq;
	logic [7:0] ev; // engine event pulses
	logic id_chain_n = 1'h1; // spare flag, connected to nothing; low once joined
	int fail_count = 0;
	int tests_run = 0;
	tnc_core u_tnc_core (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .tx_done(ev[0]), .tx_ok(ev[1]), .rx_done(ev[2]),
		.recon_seen(ev[3]), .token_seen(ev[4]), .rx_activity(ev[5]), .dup_detect(ev[6]),
		.my_recon(ev[7]), .core_run, .tx_drive_en, .tx_start(), .rx_arm, .irq);
	tnc_engine u_tnc_engine (.aclk, .aresetn, .rx_arm, .ev);
	initial forever #50 aclk = ~aclk;
	task final_report;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// each channel is released at the rising edge that takes it; one idle edge between calls
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic done;
		n = 0;
		done = 1'h0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!done && n < 50) begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid && s_axi_bready) begin
				done = 1'h1;
				s_axi_bready <= 1'h0;
			end
		end
		@(posedge aclk);
		chk("write done", 32'h1, {31'h0, done});
		if (!done) final_report();
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		int n;
		logic done;
		n = 0;
		done = 1'h0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (!done && n < 50) begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
			// data and response are taken at the handshake edge itself
			if (s_axi_rvalid && s_axi_rready) begin
				done = 1'h1;
				rd_data = s_axi_rdata;
				rd_resp = s_axi_rresp;
				s_axi_rready <= 1'h0;
			end
		end
		@(posedge aclk);
		if (!done) begin
			chk("read done", 32'h1, 32'h0);
			final_report();
		end
		chk($sformatf("rdata at %h", a), e, rd_data & m);
	endtask : rd
	// pins are compared at the falling edge, where they are settled
	task automatic pin(input string n, input logic e, ref logic s);
		@(negedge aclk);
		chk(n, {31'h0, e}, {31'h0, s});
		@(posedge aclk);
	endtask : pin
	task reset_dut;
		aresetn <= 1'h0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
	endtask : reset_dut
	initial begin
		reset_dut();
		wr(`TNC_OFF_NODEID, 32'h0);
		pin("core_run", 1'h0, core_run);
		u_tnc_engine.fire(8'h70);
		rd(`TNC_OFF_DIAG, 32'hF, 32'h0);
		wr(`TNC_OFF_NODEID, 32'h05);
		pin("core_run", 1'h1, core_run);
		u_tnc_engine.fire(8'h40);
		rd(`TNC_OFF_DIAG, 32'hF, 32'h4);
		u_tnc_engine.fire(8'h30);
		// settling wait kept short: the model network has no traffic to wait for
		repeat (100) @(posedge aclk);
		rd(`TNC_OFF_DIAG, 32'hF, 32'h3);
		rd(`TNC_OFF_DIAG, 32'hF, 32'h0);
		wr(`TNC_OFF_CONFIG, 32'h20);
		pin("tx_drive_en", 1'h1, tx_drive_en);
		id_chain_n <= 1'h0;
		wr(`TNC_OFF_CMD, {28'h0, `TNC_CMD_RX});
		wr(`TNC_OFF_CMD, {28'h0, `TNC_CMD_RX});
		for (int i = 0; i < 2; i++) begin
			wr(`TNC_OFF_CMD, {28'h0, `TNC_CMD_TX});
		end
		rd(`TNC_OFF_DEPTH, 32'hF, 32'h5);
		wr(`TNC_OFF_IMASK, 32'h4);
		u_tnc_engine.fire(8'h04);
		pin("irq", 1'h1, irq);
		wr(`TNC_OFF_CMD, {28'h0, `TNC_CMD_CLR_RX});
		pin("irq", 1'h1, irq);
		wr(`TNC_OFF_IMASK, 32'h0);
		pin("irq", 1'h0, irq);
		rd(8'h40, 32'hFFFFFFFF, 32'h0);
		chk("rresp", {30'h0, `TNC_RESP_SLVERR}, {30'h0, rd_resp});
		reset_dut();
		wr(`TNC_OFF_SETUP, 32'h1);
		wr(`TNC_OFF_NODEID, 32'h05);
		for (int i = 0; i < 2; i++) begin
			wr(`TNC_OFF_CMD, {28'h0, `TNC_CMD_RX});
		end
		for (int i = 0; i < 3; i++) begin
			wr(`TNC_OFF_CMD, {28'h0, `TNC_CMD_TX});
		end
		wr(`TNC_OFF_CMD, {28'h0, `TNC_CMD_RX});
		rd(`TNC_OFF_DEPTH, 32'hF, 32'hA);
		wr(`TNC_OFF_IMASK, 32'h5);
		u_tnc_engine.fire(8'h04);
		pin("irq", 1'h1, irq);
		wr(`TNC_OFF_CMD, {28'h0, `TNC_CMD_CLR_RX});
		pin("irq", 1'h0, irq);
		rd(`TNC_OFF_DEPTH, 32'hF, 32'h6);
		u_tnc_engine.fire(8'h03);
		rd(`TNC_OFF_DEPTH, 32'h3, 32'h1);
		rd(`TNC_OFF_STATUS, 32'h1, 32'h1);
		pin("irq", 1'h1, irq);
		wr(`TNC_OFF_STATUS, 32'h1);
		pin("irq", 1'h0, irq);
		final_report();
	end
endmodule : token_net_core_host_control_test
